/* File: hw/pfmux_pkg.sv */
// Package for the port 1 pin-function selector
package pfmux_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_FUNC_SEL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_DIRECTION  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_DATA       = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_EDGE_CTRL  = 4'hC;
  localparam logic [7:0] FUNC_SEL_RST = 8'h00;
  localparam logic [7:0] DIR_RST      = 8'h00;
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [2:0] EDGE_RST     = 3'h0;
  localparam logic [7:0] FUNC_WMASK   = 8'hF7;
  localparam int unsigned BIT_INT3  = 7;
  localparam int unsigned BIT_INT2  = 6;
  localparam int unsigned BIT_INT1  = 5;
  localparam int unsigned BIT_PWM   = 4;
  localparam int unsigned BIT_TFH   = 2;
  localparam int unsigned BIT_TFL   = 1;
  localparam int unsigned BIT_WATCH = 0;
  localparam logic [2:0] TIMER_C_EVENT_MODE = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hw/pfmux_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pfmux_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* File: hw/pfmux_edge.sv */
// Selectable edge detector for one event input
`timescale 1ns/1ps
module pfmux_edge (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic enable,
  input  wire logic rising,
  input  wire logic level,
  output logic      pulse
);
  logic prev_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_r <= 1'b0;
    else
      prev_r <= level;
  end

  // Registered pulse, gated so a disabled pin never reports an edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pulse <= 1'b0;
    else
      pulse <= enable && (rising ? (level && !prev_r) : (!level && prev_r));
  end
endmodule

/* File: hw/pfmux_top.sv */
// Port 1 pin-function selector with AXI4-Lite register access
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module pfmux_top #(
  parameter int unsigned PINS = 8
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [pfmux_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic      [1:0]                    s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [pfmux_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic      [31:0]                   s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [PINS-1:0]               pin_in,
  output logic      [PINS-1:0]               pin_out,
  output logic      [PINS-1:0]               pin_oe_n,
  input  wire logic                          pwm_out_src,
  input  wire logic                          timer_f_high_output,
  input  wire logic                          timer_f_low_output,
  input  wire logic                          watch_clock_output,
  input  wire logic [2:0]                    timer_f_clock_select,
  input  wire logic [2:0]                    timer_c_clock_field,
  output logic                               ext_int3_event,
  output logic                               ext_int2_event,
  output logic                               ext_int1_event,
  output logic                               timer_f_event_input,
  output logic                               timer_c_event_input,
  output logic                               timer_b_event_input
);
  logic [7:0]       port1_function_select_r;
  logic [PINS-1:0]  port1_direction_r;
  logic [PINS-1:0]  port1_data_r;
  logic [2:0]       edge_rising_r;
  logic [PINS-1:0]  pin_sync;
  logic [PINS-1:0]  periph_out;
  logic [PINS-1:0]  periph_drive;
  logic [PINS-1:0]  pin_drive;
  logic [2:0]       ev_pulse;
  logic             aw_held_r;
  logic             w_held_r;
  logic [pfmux_pkg::ADDR_W-1:0] aw_addr_r;
  logic [31:0]      w_data_r;
  logic [3:0]       w_strb_r;
  logic             do_write;
  logic             do_read;

  function automatic logic mapped(input logic [pfmux_pkg::ADDR_W-1:0] a);
    mapped = (a == pfmux_pkg::OFF_FUNC_SEL) || (a == pfmux_pkg::OFF_DIRECTION) ||
             (a == pfmux_pkg::OFF_DATA) || (a == pfmux_pkg::OFF_EDGE_CTRL);
  endfunction

  // Write address and data may arrive in either order; each is held once taken
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pfmux_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr_r) ? pfmux_pkg::RESP_OKAY : pfmux_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Register stores; only byte lane 0 carries data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port1_function_select_r <= pfmux_pkg::FUNC_SEL_RST;
    else if (do_write && w_strb_r[0] && aw_addr_r == pfmux_pkg::OFF_FUNC_SEL)
      port1_function_select_r <= w_data_r[7:0] & pfmux_pkg::FUNC_WMASK;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port1_direction_r <= pfmux_pkg::DIR_RST;
    else if (do_write && w_strb_r[0] && aw_addr_r == pfmux_pkg::OFF_DIRECTION)
      port1_direction_r <= w_data_r[PINS-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port1_data_r <= pfmux_pkg::DATA_RST;
    else if (do_write && w_strb_r[0] && aw_addr_r == pfmux_pkg::OFF_DATA)
      port1_data_r <= w_data_r[PINS-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      edge_rising_r <= pfmux_pkg::EDGE_RST;
    else if (do_write && w_strb_r[0] && aw_addr_r == pfmux_pkg::OFF_EDGE_CTRL)
      edge_rising_r <= w_data_r[2:0];
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= pfmux_pkg::RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? pfmux_pkg::RESP_OKAY : pfmux_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        pfmux_pkg::OFF_FUNC_SEL:  s_axi_rdata <= {24'h000000, port1_function_select_r};
        pfmux_pkg::OFF_DIRECTION: s_axi_rdata <= {24'h000000, port1_direction_r};
        // Output pins read back latched data, input pins the synced level
        pfmux_pkg::OFF_DATA:
          s_axi_rdata <= {24'h000000,
                          (port1_data_r & port1_direction_r) | (pin_sync & ~port1_direction_r)};
        pfmux_pkg::OFF_EDGE_CTRL: s_axi_rdata <= {29'h0, edge_rising_r};
        default:                  s_axi_rdata <= '0;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  pfmux_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pin_in),
    .q       (pin_sync)
  );

  // Peripheral outputs; event pins never drive when selected
  always_comb
  begin
    periph_out   = '0;
    periph_drive = '0;
    periph_out[pfmux_pkg::BIT_PWM]     = pwm_out_src;
    periph_out[pfmux_pkg::BIT_TFH]     = timer_f_high_output;
    periph_out[pfmux_pkg::BIT_TFL]     = timer_f_low_output;
    periph_out[pfmux_pkg::BIT_WATCH]   = watch_clock_output;
    periph_drive[pfmux_pkg::BIT_PWM]   = 1'b1;
    periph_drive[pfmux_pkg::BIT_TFH]   = 1'b1;
    periph_drive[pfmux_pkg::BIT_TFL]   = 1'b1;
    periph_drive[pfmux_pkg::BIT_WATCH] = 1'b1;
  end

  // Selected pins follow their function; direction and data ignored there
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      if (i < 8 && port1_function_select_r[i])
        pin_drive[i] = periph_drive[i];
      else
        pin_drive[i] = port1_direction_r[i];
    end
  end

  // Registered pin data; oe_n kept low only while the pin is driven
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end
    else
    begin
      pin_out  <= (periph_out & port1_function_select_r[PINS-1:0]) |
                  (port1_data_r & ~port1_function_select_r[PINS-1:0]);
      pin_oe_n <= ~pin_drive;
    end
  end

  for (genvar g = 0; g < 3; g++)
  begin : g_edge
    pfmux_edge u_edge (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (port1_function_select_r[pfmux_pkg::BIT_INT1 + g]),
      .rising  (edge_rising_r[g]),
      .level   (pin_sync[pfmux_pkg::BIT_INT1 + g]),
      .pulse   (ev_pulse[g])
    );
  end

  // Interrupt enables live in the interrupt controller
  assign ext_int1_event      = ev_pulse[0];
  assign ext_int2_event      = ev_pulse[1];
  assign ext_int3_event      = ev_pulse[2];
  assign timer_b_event_input = ev_pulse[0];
  assign timer_c_event_input = ev_pulse[1] &&
                               (timer_c_clock_field == pfmux_pkg::TIMER_C_EVENT_MODE);
  assign timer_f_event_input = ev_pulse[2] && !timer_f_clock_select[2];
endmodule

/* File: testbench/pfmux_chk_sva.sv */
// Port-level assertions for the port 1 pin-function selector
`timescale 1ns/1ps
module pfmux_chk #(
  parameter int unsigned PINS = 8
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic [PINS-1:0] pin_oe_n,
  input wire logic [2:0]      timer_f_clock_select,
  input wire logic [2:0]      timer_c_clock_field,
  input wire logic            ext_int3_event,
  input wire logic            ext_int2_event,
  input wire logic            ext_int1_event,
  input wire logic            timer_f_event_input,
  input wire logic            timer_c_event_input,
  input wire logic            timer_b_event_input
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  rd_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not the inverse of rvalid");
  rd_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  evt_pulse_a: assert property (ext_int3_event |=> !ext_int3_event)
    else $error("event pulse longer than one cycle");
  evt_input_a: assert property
    (({ext_int3_event, ext_int2_event, ext_int1_event} & ~pin_oe_n[7:5]) == 3'h0)
    else $error("event raised on a driven pin");
  tmr_b_a: assert property (timer_b_event_input == ext_int1_event)
    else $error("timer B event differs from pin 5 event");
  tmr_c_a: assert property (timer_c_event_input ==
    (ext_int2_event && timer_c_clock_field == pfmux_pkg::TIMER_C_EVENT_MODE))
    else $error("timer C event gating wrong");
  tmr_f_a: assert property (timer_f_event_input ==
    (ext_int3_event && !timer_f_clock_select[2]))
    else $error("timer F event gating wrong");
  cover property (s_axi_rvalid);
  cover property (s_axi_bvalid);
  cover property (timer_f_event_input);
endmodule

/* File: testbench/pfmux_pins.sv */
// Pin model: outside drivers resolved against the port's own drive
`timescale 1ns/1ps
module pfmux_pins #(
  parameter int unsigned PINS = 8
) (
  input  wire logic [PINS-1:0] pin_out,
  input  wire logic [PINS-1:0] pin_oe_n,
  input  wire logic [PINS-1:0] ext_lvl,
  output logic      [PINS-1:0] pin_in
);
  // Released pins follow the outside source, driven ones the port
  assign pin_in = (ext_lvl & pin_oe_n) | (pin_out & ~pin_oe_n);
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the port 1 pin-function selector
`timescale 1ns/1ps
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  pin_in, pin_out, pin_oe_n, ext_lvl = 8'h00;
  logic        pwm_out_src = 1'b0, timer_f_high_output = 1'b0;
  logic        timer_f_low_output = 1'b0, watch_clock_output = 1'b0;
  logic [2:0]  timer_f_clock_select = 3'h0, timer_c_clock_field = 3'h0;
  logic        ext_int3_event, ext_int2_event, ext_int1_event;
  logic        timer_f_event_input, timer_c_event_input, timer_b_event_input;
  logic [5:0]  e;
  int          err_total = 0, comparisons = 0, cnt[6] = '{6{0}}, base[6];
  wire  [5:0]  evt = {timer_f_event_input, timer_c_event_input, timer_b_event_input,
                      ext_int3_event, ext_int2_event, ext_int1_event};

  pfmux_top #(.PINS(8)) i_pfmux_top (.*);
  pfmux_pins #(.PINS(8)) i_pfmux_pins (.*);

  always #4 aclk = ~aclk;
  always @(posedge aclk)
    foreach (cnt[i]) cnt[i] <= cnt[i] + int'(evt[i]);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Handshakes sampled at the rising edge, before that edge's updates land
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic done;
    int   n;
    done = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    while (!done && n < 50)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      done = w ? (s_axi_bvalid && s_axi_bready) : (s_axi_rvalid && s_axi_rready);
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (!done)
      err_total++;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] er = pfmux_pkg::RESP_OKAY);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b1, a, d, q, r);
    chk("bresp", 32'(r), 32'(er));
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                    input logic [1:0] er = pfmux_pkg::RESP_OKAY);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, a, 8'h00, q, r);
    chk("rdata", q, ed);
    chk("rresp", 32'(r), 32'(er));
  endtask

  // Pins follow a store next edge; inputs add two sync flops and an edge stage
  task automatic settle;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic end_of_test;
    $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge aclk);
    err_total++;
    end_of_test();
  end

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk("oe_rst", 32'(pin_oe_n), 32'h000000FF);
    rd(pfmux_pkg::OFF_FUNC_SEL, 32'h00000000);
    wr(pfmux_pkg::OFF_FUNC_SEL, 8'hF7);
    rd(pfmux_pkg::OFF_FUNC_SEL, 32'h000000F7);
    wr(pfmux_pkg::OFF_FUNC_SEL, 8'hA7);
    rd(pfmux_pkg::OFF_FUNC_SEL, 32'h000000A7);
    wr(4'h2, 8'h01, pfmux_pkg::RESP_SLVERR);
    rd(4'h2, 32'h00000000, pfmux_pkg::RESP_SLVERR);
    wr(pfmux_pkg::OFF_FUNC_SEL, 8'h00);
    wr(pfmux_pkg::OFF_DIRECTION, 8'hA5);
    wr(pfmux_pkg::OFF_DATA, 8'h3C);
    ext_lvl <= 8'hF0;
    settle();
    chk("oe_io", 32'(pin_oe_n), 32'h0000005A);
    chk("out_io", 32'(pin_out & 8'hA5), 32'h00000024);
    rd(pfmux_pkg::OFF_DATA, 32'h00000074);
    wr(pfmux_pkg::OFF_DATA, 8'h00);
    ext_lvl <= 8'h00;
    wr(pfmux_pkg::OFF_DIRECTION, 8'h00);
    wr(pfmux_pkg::OFF_FUNC_SEL, 8'h17);
    for (int s = 0; s < 2; s++)
    begin
      @(posedge aclk);
      {pwm_out_src, timer_f_high_output, timer_f_low_output, watch_clock_output} <=
        s[0] ? 4'hA : 4'h5;
      settle();
      chk("oe_fn", 32'(pin_oe_n), 32'h000000E8);
      chk("out_fn", 32'({pin_out[4], pin_out[2:0]}), s[0] ? 32'hA : 32'h5);
    end
    wr(pfmux_pkg::OFF_DIRECTION, 8'hFF);
    wr(pfmux_pkg::OFF_EDGE_CTRL, 8'h05);
    wr(pfmux_pkg::OFF_FUNC_SEL, 8'hE0);
    settle();
    chk("oe_evt", 32'(pin_oe_n), 32'h000000E0);
    // Interrupt enables sit outside; timer use assumes them cleared
    for (int s = 0; s < 4; s++)
    begin
      base = cnt;
      @(posedge aclk);
      timer_f_clock_select <= s[1] ? 3'h4 : 3'h0;
      timer_c_clock_field <= s[1] ? 3'h6 : pfmux_pkg::TIMER_C_EVENT_MODE;
      ext_lvl[7:5] <= s[0] ? 3'h0 : 3'h7;
      settle();
      e = {!s[0] && !s[1], s[0] && !s[1], !s[0], !s[0], s[0] == 1, !s[0]};
      foreach (cnt[i]) chk("evt_cnt", 32'(cnt[i] - base[i]), 32'(e[i]));
    end
    end_of_test();
  end
endmodule

bind pfmux_top pfmux_chk #(.PINS(PINS)) i_pfmux_chk (.*);
